// *** logic/wdc_diameter_comp.sv ***
// Functional notes
// [RQ1] Feedback modes: compensation is on with enable input on and PID code 40 or 41.
// [RQ2] In those modes compensation is off when the enable input is off or the PID code is 0.
// [RQ3] Sensorless torque control and compensation are available only while enable is on.
// [RQ4] Compensation runs alone with enable and bypass on, or enable on and all gains 9999.
// [RQ5] A terminal whose function code is 114, 115 or 116 drives enable, hold or bypass.
// [RQ6] Line speed method: diameter is line speed times 1000 over pi, motor speed and gear ratio.
// [RQ7] Thickness method: initial diameter plus (wind) or minus (unwind) 2*thickness*turns*ratio.
// [RQ8] Motor speed: measured (vector), estimated (sensorless), from frequency (V/F, flux).
// [RQ9] Frequency to speed uses the pole count, or 4 poles when the setting holds 9999.
// [RQ10] Compensation speed is line speed command over pi, stored diameter and gear ratio.
// [RQ11] Clearing loads the minimum diameter when winding and the maximum when unwinding.
// [RQ12] The diameter converts the line speed command to speed and tension to torque.
// [RQ13] While the hold input is on the diameter is not updated.
// [RQ14] While the change limit holds 9999 the diameter is not updated.
// [RQ15] A zero motor speed skips the line speed division and keeps the old diameter.
`timescale 1ns/100ps
module wdc_diameter_comp import wdc_pkg::*; #(
  parameter int unsigned CALC_DIV = CALC_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [TERM_COUNT-1:0] termIn,
  input wire wdc_code_t [TERM_COUNT-1:0] termFunc,
  input wire wdc_cfg_t cfg,
  input wire wdc_meas_t meas,
  input wire logic diamClear,
  output wdc_stat_t stat
);
  wdc_core_t q;
  wdc_core_t d;

  logic compEnIn;
  logic holdIn;
  logic bypassIn;
  logic pidOk;
  logic gainsOff;
  logic calcOk;
  logic tick;
  logic freqBased;
  logic [7:0] polesEff;
  logic [15:0] speedSel;
  logic [63:0] lineNumer;
  logic [63:0] lineDenom;
  logic [63:0] thickNumer;
  logic [63:0] thickDenom;
  logic [63:0] compNumer;
  logic [63:0] compDenom;
  logic [16:0] diamSum;
  logic divBusy;
  logic divDone;
  logic [DIV_W-1:0] divQuot;

  function automatic logic [15:0] sat16(input logic [63:0] v);
    return (v > 64'h0000_0000_0000_FFFF) ? 16'hFFFF : v[15:0];
  endfunction

  wdc_divider u_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(q.divStart),
    .numer(q.divNumer),
    .denom(q.divDenom),
    .busy(divBusy),
    .done(divDone),
    .quot(divQuot)
  );

  always_comb begin
    d = q;
    d.divStart = 1'b0;
    // terminal pins pass two flip-flops before use
    d.termMeta = termIn;
    d.termSync = q.termMeta;
    compEnIn = 1'b0;
    holdIn = 1'b0;
    bypassIn = 1'b0;
    for (int i = 0; i < TERM_COUNT; i++) begin
      if (termFunc[i] == FUNC_COMP_EN) compEnIn = compEnIn | q.termSync[i]; // RQ5
      if (termFunc[i] == FUNC_DIAM_HOLD) holdIn = holdIn | q.termSync[i]; // RQ5
      if (termFunc[i] == FUNC_BYPASS) bypassIn = bypassIn | q.termSync[i]; // RQ5
    end

    pidOk = (cfg.pidActionSelect == PID_DIAM_A) || (cfg.pidActionSelect == PID_DIAM_B);
    gainsOff = (cfg.pidProportionalBand == CODE_DISABLED) &&
               (cfg.pidIntegralTime == CODE_DISABLED) &&
               (cfg.pidDifferentialTime == CODE_DISABLED);
    if (cfg.fbMode == FB_SENSORLESS_TRQ) begin
      d.stat.compEnabled = compEnIn; // RQ3
    end else begin
      d.stat.compEnabled = compEnIn && pidOk; // RQ1 RQ2
    end
    d.stat.sensorlessAvail = compEnIn; // RQ3
    d.stat.compOnly = compEnIn && (bypassIn || gainsOff); // RQ4
    calcOk = q.stat.compEnabled && (cfg.diameterChangeLimit != CODE_DISABLED) && // RQ14
             !holdIn; // RQ13
    d.stat.calcActive = calcOk;

    // motor speed source by control method
    polesEff = (cfg.motorPoleCount == CODE_DISABLED) ? DEFAULT_POLES :
               cfg.motorPoleCount[7:0]; // RQ9
    freqBased = 1'b0;
    case (cfg.ctrlMethod)
      CM_VECTOR: speedSel = meas.measSpeed; // RQ8
      CM_SENSORLESS: speedSel = meas.estSpeed; // RQ8
      CM_VF, CM_FLUX: begin
        speedSel = meas.outFreq; // RQ8
        freqBased = 1'b1;
      end
      default: speedSel = meas.measSpeed;
    endcase

    // D = V*1000 / (pi * n * Z), Z = num/den, n = 120 f / p for frequency
    lineNumer = 64'(meas.lineSpeed) * M_TO_MM * 64'(cfg.gearDen) * PI_DEN; // RQ6
    lineDenom = LINE_SPEED_DIV * PI_NUM * 64'(cfg.gearNum) * 64'(speedSel); // RQ6
    if (freqBased) begin
      lineNumer = lineNumer * HZ_SCALE * 64'(polesEff); // RQ9
      lineDenom = lineDenom * RPM_PER_HZ_POLE;
    end
    thickNumer = THICK_FACTOR * 64'(cfg.thickness) * 64'(meas.rollRotations) *
                 64'(cfg.gearNum); // RQ7
    thickDenom = 64'(cfg.gearDen) * UM_PER_MM;
    // w = V* / (pi * D * Z)
    compNumer = 64'(meas.lineSpeedCmd) * M_TO_MM * 64'(cfg.gearDen) * PI_DEN; // RQ10
    compDenom = LINE_SPEED_DIV * PI_NUM * 64'(q.stat.diameter) * 64'(cfg.gearNum); // RQ10

    tick = (q.tickCnt == TICK_W'(CALC_DIV - 1));
    d.tickCnt = tick ? '0 : TICK_W'(q.tickCnt + 1'b1);

    diamSum = '0;
    case (q.st)
      ST_IDLE: begin
        if (tick) begin
          d.divStart = 1'b1;
          if (calcOk && cfg.thicknessMethod) begin
            d.divNumer = thickNumer;
            d.divDenom = thickDenom;
            d.st = ST_THICK;
          end else if (calcOk && speedSel != 16'h0000) begin
            d.divNumer = lineNumer;
            d.divDenom = lineDenom;
            d.st = ST_DIAM;
          end else begin
            // zero speed or no calculation: stored diameter is used
            d.divNumer = compNumer; // RQ15
            d.divDenom = compDenom;
            d.st = ST_COMP;
          end
        end
      end
      ST_DIAM: begin
        if (divDone) begin
          if (calcOk) d.stat.diameter = sat16(divQuot); // RQ6 RQ13 RQ14
          d.st = ST_COMP;
        end
      end
      ST_THICK: begin
        if (divDone) begin
          if (cfg.shaftDirectionSelect) begin
            diamSum = {1'b0, cfg.diamInit} - {1'b0, sat16(divQuot)}; // RQ7
            if (calcOk) d.stat.diameter = diamSum[16] ? 16'h0000 : diamSum[15:0];
          end else begin
            diamSum = {1'b0, cfg.diamInit} + {1'b0, sat16(divQuot)}; // RQ7
            if (calcOk) d.stat.diameter = diamSum[16] ? 16'hFFFF : diamSum[15:0];
          end
          d.st = ST_COMP;
        end
      end
      ST_COMP: begin
        if (divDone) begin
          d.stat.compSpeed = sat16(divQuot); // RQ10 RQ12
          d.st = ST_IDLE;
        end
      end
      default: d.st = ST_IDLE;
    endcase

    // the comp division of a chain is launched on entry to ST_COMP
    if (q.st != ST_COMP && d.st == ST_COMP && q.st != ST_IDLE) begin
      d.divStart = 1'b1;
      d.divNumer = compNumer;
      d.divDenom = 64'(LINE_SPEED_DIV * PI_NUM * 64'(d.stat.diameter) * 64'(cfg.gearNum));
    end

    if (diamClear) begin
      d.stat.diameter = cfg.shaftDirectionSelect ? cfg.diamMax : cfg.diamMin; // RQ11
    end

    // torque = tension * radius
    d.stat.torqueCmd = 32'(({16'h0000, meas.tensionCmd} * {16'h0000, q.stat.diameter})
                           >> 1); // RQ12
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.stat.diameter <= DIAM_RESET;
    end else begin
      q <= d;
    end
  end

  assign stat = q.stat;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  comp_en_feedback_a: assert property ( // RQ1
    (cfg.fbMode != FB_SENSORLESS_TRQ && compEnIn && pidOk) |=> stat.compEnabled
  ) else $error("compensation not enabled with enable input and PID code 40/41");

  comp_dis_feedback_a: assert property ( // RQ2
    (cfg.fbMode != FB_SENSORLESS_TRQ && (!compEnIn || cfg.pidActionSelect == PID_OFF))
      |=> !stat.compEnabled
  ) else $error("compensation enabled while enable off or PID code zero");

  sensorless_avail_a: assert property ( // RQ3
    ##1 (stat.sensorlessAvail == $past(compEnIn)) && (cfg.fbMode != FB_SENSORLESS_TRQ ||
      $past(cfg.fbMode) != FB_SENSORLESS_TRQ || stat.compEnabled == $past(compEnIn))
  ) else $error("sensorless availability does not follow enable input");

  comp_only_a: assert property ( // RQ4
    ##1 stat.compOnly == $past(compEnIn && (bypassIn || gainsOff))
  ) else $error("compensation-only state wrong");

  sequence termEnHigh;
    (termFunc[0] == FUNC_COMP_EN && termIn[0]) [*2];
  endsequence

  term_route_en_a: assert property ( // RQ5
    (termEnHigh ##1 termFunc[0] == FUNC_COMP_EN) |-> compEnIn
  ) else $error("terminal assigned to enable did not reach enable after two stages");

  sequence holdSeen;
    holdIn && !diamClear;
  endsequence

  hold_keeps_diam_a: assert property ( // RQ13
    holdSeen |=> $stable(stat.diameter)
  ) else $error("diameter changed while hold input on");

  limit_off_keeps_a: assert property ( // RQ14
    (cfg.diameterChangeLimit == CODE_DISABLED && !diamClear) |=> $stable(stat.diameter)
  ) else $error("diameter changed while change limit disabled");

  clear_load_a: assert property ( // RQ11
    diamClear |=> stat.diameter ==
      ($past(cfg.shaftDirectionSelect) ? $past(cfg.diamMax) : $past(cfg.diamMin))
  ) else $error("cleared diameter not min for winding or max for unwinding");

  zero_speed_skip_a: assert property ( // RQ15
    (q.st == ST_IDLE && tick && !cfg.thicknessMethod && speedSel == 16'h0000)
      |=> q.st == ST_COMP
  ) else $error("line speed division started with zero motor speed");

  pole_default_a: assert property ( // RQ9
    (cfg.motorPoleCount == CODE_DISABLED) |-> polesEff == DEFAULT_POLES
  ) else $error("disabled pole count did not assume four poles");

  speed_source_a: assert property ( // RQ8
    (cfg.ctrlMethod == CM_SENSORLESS) |-> (speedSel == meas.estSpeed && !freqBased)
  ) else $error("sensorless vector did not use estimated speed");

  torque_track_a: assert property ( // RQ12
    ##1 stat.torqueCmd == ((32'($past(meas.tensionCmd)) * 32'($past(stat.diameter))) >> 1)
  ) else $error("torque command does not follow tension times radius");

  calc_gate_a: assert property ( // RQ13 RQ14
    (holdIn || cfg.diameterChangeLimit == CODE_DISABLED || !stat.compEnabled)
      |=> !stat.calcActive
  ) else $error("calculation active while hold, limit off or compensation off");

  enable_off_a: assert property ( // RQ3
    !compEnIn |=> (!stat.compEnabled && !stat.sensorlessAvail)
  ) else $error("compensation or sensorless control available with enable off");

  sequence lineStart;
    q.st == ST_IDLE && tick && calcOk && !cfg.thicknessMethod && speedSel != 16'h0000;
  endsequence

  sequence thickStart;
    q.st == ST_IDLE && tick && calcOk && cfg.thicknessMethod;
  endsequence

  sequence quotReady;
    (q.st == ST_DIAM || q.st == ST_THICK) && divDone;
  endsequence

  sequence thickLands;
    q.st == ST_THICK && divDone && calcOk && !diamClear;
  endsequence

  line_launch_a: assert property ( // RQ6
    lineStart |=> (q.st == ST_DIAM && q.divStart)
  ) else $error("line speed division not launched on tick");

  thick_launch_a: assert property ( // RQ7
    thickStart |=> (q.st == ST_THICK && q.divStart)
  ) else $error("thickness division not launched on tick");

  diam_write_a: assert property ( // RQ6
    (q.st == ST_DIAM && divDone && calcOk && !diamClear)
      |=> stat.diameter == sat16($past(divQuot))
  ) else $error("line speed quotient not written to diameter");

  wind_grows_a: assert property ( // RQ7
    (thickLands ##0 !cfg.shaftDirectionSelect) |=> stat.diameter >= $past(cfg.diamInit)
  ) else $error("winding thickness result below initial diameter");

  unwind_shrinks_a: assert property ( // RQ7
    (thickLands ##0 cfg.shaftDirectionSelect) |=> stat.diameter <= $past(cfg.diamInit)
  ) else $error("unwinding thickness result above initial diameter");

  comp_launch_a: assert property ( // RQ10
    quotReady |=> (q.st == ST_COMP && q.divStart)
  ) else $error("compensation division not launched after diameter");

  comp_write_a: assert property ( // RQ10 RQ12
    (q.st == ST_COMP && divDone)
      |=> (q.st == ST_IDLE && stat.compSpeed == sat16($past(divQuot)))
  ) else $error("compensation quotient not written to compensation speed");

endmodule

// *** logic/wdc_pkg.sv ***
package wdc_pkg;

  // clock and calculation cycle
  localparam int CLK_PERIOD_NS = 4;
  localparam int CALC_PERIOD_NS = 1000;
  localparam int CALC_CYCLES = CALC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 8;

  // input terminals and their function codes
  localparam int TERM_COUNT = 12;
  localparam logic [15:0] FUNC_COMP_EN = 16'h0072;
  localparam logic [15:0] FUNC_DIAM_HOLD = 16'h0073;
  localparam logic [15:0] FUNC_BYPASS = 16'h0074;

  // setting codes
  localparam logic [15:0] CODE_DISABLED = 16'h270F;
  localparam logic [15:0] PID_DIAM_A = 16'h0028;
  localparam logic [15:0] PID_DIAM_B = 16'h0029;
  localparam logic [15:0] PID_OFF = 16'h0000;
  localparam logic [7:0] DEFAULT_POLES = 8'h04;

  // arithmetic scaling: pi as 355/113, line speed in 0.1 m/min,
  // output frequency in 0.01 Hz, thickness in um, diameter in mm
  localparam logic [63:0] PI_NUM = 64'h0000_0000_0000_0163;
  localparam logic [63:0] PI_DEN = 64'h0000_0000_0000_0071;
  localparam logic [63:0] M_TO_MM = 64'h0000_0000_0000_03E8;
  localparam logic [63:0] LINE_SPEED_DIV = 64'h0000_0000_0000_000A;
  localparam logic [63:0] HZ_SCALE = 64'h0000_0000_0000_0064;
  localparam logic [63:0] RPM_PER_HZ_POLE = 64'h0000_0000_0000_0078;
  localparam logic [63:0] THICK_FACTOR = 64'h0000_0000_0000_0002;
  localparam logic [63:0] UM_PER_MM = 64'h0000_0000_0000_03E8;

  localparam int DIV_W = 64;
  localparam logic [15:0] DIAM_RESET = 16'h0000;

  typedef logic [15:0] wdc_code_t;

  typedef enum logic [1:0] {
    FB_DANCER_SPD = 2'b00,
    FB_TENS_SPD = 2'b01,
    FB_TENS_TRQ = 2'b10,
    FB_SENSORLESS_TRQ = 2'b11
  } wdc_fb_mode_t;

  typedef enum logic [1:0] {
    CM_VECTOR = 2'b00,
    CM_SENSORLESS = 2'b01,
    CM_VF = 2'b10,
    CM_FLUX = 2'b11
  } wdc_ctrl_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIAM = 2'b01,
    ST_THICK = 2'b10,
    ST_COMP = 2'b11
  } wdc_seq_t;

  typedef struct packed {
    wdc_fb_mode_t fbMode;
    wdc_ctrl_t ctrlMethod;
    logic thicknessMethod;
    logic shaftDirectionSelect;
    wdc_code_t pidActionSelect;
    wdc_code_t pidProportionalBand;
    wdc_code_t pidIntegralTime;
    wdc_code_t pidDifferentialTime;
    wdc_code_t motorPoleCount;
    wdc_code_t diameterChangeLimit;
    logic [15:0] gearNum;
    logic [15:0] gearDen;
    logic [15:0] diamInit;
    logic [15:0] diamMin;
    logic [15:0] diamMax;
    logic [15:0] thickness;
  } wdc_cfg_t;

  typedef struct packed {
    logic [15:0] lineSpeed;
    logic [15:0] measSpeed;
    logic [15:0] estSpeed;
    logic [15:0] outFreq;
    logic [23:0] rollRotations;
    logic [15:0] lineSpeedCmd;
    logic [15:0] tensionCmd;
  } wdc_meas_t;

  typedef struct packed {
    logic compEnabled;
    logic compOnly;
    logic sensorlessAvail;
    logic calcActive;
    logic [15:0] diameter;
    logic [15:0] compSpeed;
    logic [31:0] torqueCmd;
  } wdc_stat_t;

  typedef struct packed {
    wdc_seq_t st;
    logic [TERM_COUNT-1:0] termMeta;
    logic [TERM_COUNT-1:0] termSync;
    logic [TICK_W-1:0] tickCnt;
    logic divStart;
    logic [DIV_W-1:0] divNumer;
    logic [DIV_W-1:0] divDenom;
    wdc_stat_t stat;
  } wdc_core_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic [6:0] cnt;
    logic [DIV_W-1:0] den;
    logic [DIV_W-1:0] quo;
    logic [DIV_W-1:0] rem;
  } wdc_div_t;

endpackage

// *** logic/wdc_divider.sv ***
`timescale 1ns/100ps
module wdc_divider import wdc_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [DIV_W-1:0] numer,
  input wire logic [DIV_W-1:0] denom,
  output logic busy,
  output logic done,
  output logic [DIV_W-1:0] quot
);
  wdc_div_t q;
  wdc_div_t d;
  logic [DIV_W:0] trial;

  // restoring division, one quotient bit per cycle; zero divisor gives all ones
  always_comb begin
    d = q;
    d.done = 1'b0;
    trial = {q.rem, q.quo[DIV_W-1]};
    if (start && !q.busy) begin
      d.busy = 1'b1;
      d.cnt = 7'h00;
      d.den = denom;
      d.quo = numer;
      d.rem = '0;
    end else if (q.busy) begin
      if (trial >= {1'b0, q.den}) begin
        d.rem = DIV_W'(trial - {1'b0, q.den});
        d.quo = {q.quo[DIV_W-2:0], 1'b1};
      end else begin
        d.rem = trial[DIV_W-1:0];
        d.quo = {q.quo[DIV_W-2:0], 1'b0};
      end
      d.cnt = q.cnt + 7'h01;
      if (q.cnt == 7'(DIV_W - 1)) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign busy = q.busy;
  assign done = q.done;
  assign quot = q.quo;

  sequence divLaunch;
    start && !busy;
  endsequence

  property divFinishes;
    @(posedge mclk) disable iff (!rst_n) divLaunch |=> busy [*8] ##[56:60] done;
  endproperty

  div_finish_a: assert property (divFinishes) else $error("divider did not finish in 65 cycles");

endmodule

// *** test/wdc_feed_model.sv ***
`timescale 1ns/100ps
module wdc_feed_model import wdc_pkg::*; (
  input wire wdc_ctrl_t ctrlMethod,
  input wire logic [15:0] rpm,
  input wire logic [7:0] poles,
  input wire logic [15:0] lineSpeed,
  input wire logic [15:0] lineSpeedCmd,
  input wire logic [15:0] tensionCmd,
  input wire logic [23:0] rollRotations,
  output wdc_meas_t meas
);
  logic [15:0] decoy;
  logic [31:0] freq;
  // sources the control method does not use show twice the speed, so a wrong pick shows up
  always_comb begin
    decoy = rpm << 1;
    freq = (ctrlMethod inside {CM_VF, CM_FLUX}) ? {16'h0000, rpm} : {16'h0000, decoy};
    freq = freq * {24'h000000, poles} * 32'h0000000A / 32'h0000000C;
    meas.lineSpeed = lineSpeed;
    meas.measSpeed = (ctrlMethod == CM_VECTOR) ? rpm : decoy;
    meas.estSpeed = (ctrlMethod == CM_SENSORLESS) ? rpm : decoy;
    meas.outFreq = freq[15:0];
    meas.rollRotations = rollRotations;
    meas.lineSpeedCmd = lineSpeedCmd;
    meas.tensionCmd = tensionCmd;
  end
endmodule

// *** test/winding_diameter_compensation_tb_top.sv ***
`timescale 1ns/100ps
module winding_diameter_compensation_tb_top import wdc_pkg::*; ();
  localparam int unsigned CDIV = 150;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [TERM_COUNT-1:0] termIn = '0;
  wdc_code_t [TERM_COUNT-1:0] termFunc;
  wdc_cfg_t cfg;
  wdc_meas_t meas;
  logic diamClear = 1'b0;
  wdc_stat_t stat;
  logic [15:0] rpm = 16'h0153;
  logic [7:0] poles = 8'h04;
  int n_fail = 0;
  int num_checks = 0;

  always #2 mclk = ~mclk;

  wdc_feed_model model_u (.ctrlMethod(cfg.ctrlMethod), .rpm(rpm), .poles(poles),
    .lineSpeed(16'h0852), .lineSpeedCmd(16'h02C6), .tensionCmd(16'h0064),
    .rollRotations(24'h00000A), .meas(meas));

  wdc_diameter_comp #(.CALC_DIV(CDIV)) dut_u (.mclk(mclk), .rst_n(rst_n), .termIn(termIn),
    .termFunc(termFunc), .cfg(cfg), .meas(meas), .diamClear(diamClear), .stat(stat));

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic flg(input string name, input logic [2:0] exp);
    cyc(5);
    chk(name, {29'h0, exp}, {29'h0, stat.compEnabled, stat.compOnly, stat.sensorlessAvail});
  endtask

  // clear with the hold terminal on, so no calculation lands in between
  task automatic clr;
    termIn[3] = 1'b1;
    cyc(4);
    diamClear = 1'b1;
    cyc(1);
    diamClear = 1'b0;
    cyc(2);
  endtask

  task automatic run(input string name, input logic [15:0] exp);
    int i;
    clr();
    termIn[3] = 1'b0;
    for (i = 0; i < 4 * CDIV && stat.diameter !== exp; i++) cyc(1);
    if (stat.diameter !== exp) begin
      chk(name, {16'h0, exp}, {16'h0, stat.diameter});
      final_report();
    end
    chk(name, {16'h0, exp}, {16'h0, stat.diameter});
    $display("test %s done", name);
  endtask

  task automatic keep(input string name);
    clr();
    termIn[3] = 1'b0;
    cyc(3 * CDIV);
    chk(name, 32'h00000032, {16'h0, stat.diameter});
    $display("test %s done", name);
  endtask

  initial begin
    termFunc = '0;
    termFunc[0] = FUNC_COMP_EN;
    termFunc[3] = FUNC_DIAM_HOLD;
    termFunc[7] = FUNC_BYPASS;
    cfg = '{FB_DANCER_SPD, CM_VECTOR, 1'b0, 1'b0, PID_DIAM_A, 16'h0064, 16'h0064, 16'h0064,
      CODE_DISABLED, 16'h0010, 16'h0001, 16'h0001, 16'h012C, 16'h0032, 16'h0384, 16'h01F4};
    cyc(2);
    rst_n = 1'b1;
    chk("stat reset", 32'h0, {31'h0, |stat});
    flg("enable off", 3'b000);
    termIn[0] = 1'b1;
    flg("pid 40", 3'b101);
    cfg.pidActionSelect = PID_DIAM_B;
    flg("pid 41", 3'b101);
    cfg.pidActionSelect = PID_OFF;
    flg("pid 0", 3'b001);
    cfg.fbMode = FB_TENS_TRQ;
    flg("pid 0 torque", 3'b001);
    cfg.fbMode = FB_SENSORLESS_TRQ;
    flg("sensorless on", 3'b101);
    termIn[0] = 1'b0;
    flg("sensorless off", 3'b000);
    termIn[0] = 1'b1;
    cfg.fbMode = FB_TENS_SPD;
    cfg.pidActionSelect = PID_DIAM_A;
    termIn[7] = 1'b1;
    flg("bypass", 3'b111);
    termIn[7] = 1'b0;
    cfg.pidProportionalBand = CODE_DISABLED;
    cfg.pidIntegralTime = CODE_DISABLED;
    cfg.pidDifferentialTime = CODE_DISABLED;
    flg("gains off", 3'b111);
    cfg.pidIntegralTime = 16'h0064;
    flg("one gain", 3'b101);
    termFunc[0] = 16'h0000;
    termFunc[11] = FUNC_COMP_EN;
    flg("moved off", 3'b000);
    termIn[11] = 1'b1;
    flg("moved on", 3'b101);
    termIn[11] = 1'b0;
    termFunc[0] = FUNC_COMP_EN;
    $display("test flags done");
    cfg.fbMode = FB_DANCER_SPD;
    cfg.shaftDirectionSelect = 1'b1;
    clr();
    chk("clear unwind", 32'h00000384, {16'h0, stat.diameter});
    cfg.shaftDirectionSelect = 1'b0;
    clr();
    chk("clear wind", 32'h00000032, {16'h0, stat.diameter});
    cyc(3 * CDIV);
    chk("hold", 32'h00000032, {16'h0, stat.diameter});
    chk("calc held", 32'h0, {31'h0, stat.calcActive});
    chk("stored comp", 32'h000001C4, {16'h0, stat.compSpeed});
    chk("torque stored", 32'h000009C4, stat.torqueCmd);
    for (int m = 0; m < 4; m++) begin
      cfg.ctrlMethod = wdc_ctrl_t'(m);
      run("line speed", 16'h00C8);
    end
    cyc(2 * CDIV);
    chk("comp speed", 32'h00000071, {16'h0, stat.compSpeed});
    chk("torque", 32'h00002710, stat.torqueCmd);
    chk("calc active", 32'h1, {31'h0, stat.calcActive});
    cfg.ctrlMethod = CM_VF;
    cfg.motorPoleCount = 16'h0002;
    poles = 8'h02;
    run("two poles", 16'h00C8);
    rpm = 16'h0000;
    keep("zero speed");
    rpm = 16'h0153;
    cfg.diameterChangeLimit = CODE_DISABLED;
    keep("limit off");
    chk("calc limit off", 32'h0, {31'h0, stat.calcActive});
    cfg.diameterChangeLimit = 16'h0010;
    cfg.thicknessMethod = 1'b1;
    run("thick wind", 16'h0136);
    cfg.shaftDirectionSelect = 1'b1;
    run("thick unwind", 16'h0122);
    final_report();
  end
endmodule
